// ### rtl/pp_words_pkg.sv
// pp_words_pkg: bit positions, field layouts and carriers for the positioning
// process-word interpreter.
// assumes: one 125 MHz clock domain; words arrive already framed from the link layer.
package pp_words_pkg;

  // clock figures
  localparam int unsigned CLK_PERIOD_NS = 8; // sys_clk period

  // drive control word (process word 1) bit positions
  localparam int unsigned CW1_START = 0;       // start if enable present
  localparam int unsigned CW1_ESTOP = 2;       // activate emergency stop
  localparam int unsigned CW1_EXT_ERR = 3;     // raise external error
  localparam int unsigned CW1_ERR_CLR = 7;     // 0->1 clears pending error
  localparam int unsigned CW1_OUT_LSB = 12;    // bits 12..15 drive outputs 3..0

  // program control word (process word 2) bit positions
  localparam int unsigned CW2_FLAG_LSB = 0;    // bits 0..7 -> flag params 90..97
  localparam int unsigned CW2_AUTO = 8;        // 0 manual, 1 automatic
  localparam int unsigned CW2_TRIG = 9;        // 0->1 start program / reference run
  localparam int unsigned CW2_UPDATE = 10;     // 1 aborts program sequence
  localparam int unsigned CW2_FEED = 11;       // 1 interrupts positioning
  localparam int unsigned CW2_JOG_POS = 14;    // jog plus
  localparam int unsigned CW2_JOG_NEG = 15;    // jog minus

  // drive status word (process word 1) bit positions
  localparam int unsigned SW1_GEN_ERR = 0;
  localparam int unsigned SW1_ONE = 1;
  localparam int unsigned SW1_POS_REACHED = 2;
  localparam int unsigned SW1_REF_LIMIT = 3;
  localparam int unsigned SW1_POWER = 4;
  localparam int unsigned SW1_ZERO_SPEED = 5;
  localparam int unsigned SW1_ESTOP = 6;
  localparam int unsigned SW1_READY = 7;
  localparam int unsigned SW1_ENABLE = 8;
  localparam int unsigned SW1_OUT0 = 9;
  localparam int unsigned SW1_OUT1 = 10;
  localparam int unsigned SW1_IN_LSB = 11;     // bits 11..15 = inputs 4..0

  // program status word (process word 2) bit positions
  localparam int unsigned SW2_FLAG_LSB = 0;    // bits 0..7 <- flag params 80..87
  localparam int unsigned SW2_REF_DONE = 8;
  localparam int unsigned SW2_AUTO = 9;
  localparam int unsigned SW2_PROG = 10;
  localparam int unsigned SW2_FEED = 12;
  localparam int unsigned SW2_UPDATE = 13;
  localparam int unsigned SW2_SYNC = 14;
  localparam int unsigned SW2_LAG = 15;

  // output function selector code that hands an output to the bus
  localparam logic [3:0] OUTPUT_OPTION_TWO = 4'h2;

  // reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [31:0] VAR_RESET = 32'h0000_0000;

  // received cyclic words, one strobe per cycle of the bus
  typedef struct packed {
    logic [15:0] word1; // drive control word
    logic [15:0] word2; // program control word
    logic [15:0] word3; // variable high half
    logic [15:0] word4; // variable low half
  } rx_words_s;

  // state fed back by the motion and program engines
  typedef struct packed {
    logic gen_err;
    logic pos_reached;
    logic ref_limit;
    logic power_on;
    logic zero_speed;
    logic ready;
    logic ref_done;
    logic prog_active;
    logic sync_active;
    logic lag_limit;
    logic [7:0] flags_out; // flag params 80..87
  } engine_state_s;

  // decoded commands to the engines
  typedef struct packed {
    logic drive_enable;
    logic estop;
    logic ext_err;
    logic err_clear;   // pulse
    logic auto_mode;
    logic prog_start;  // pulse
    logic ref_start;   // pulse
    logic prog_abort;
    logic feed_hold;
    logic jog_pos;
    logic jog_neg;
    logic [7:0] flags_in; // flag params 90..97
  } drive_cmd_s;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00, // no word yet received
    LINK_RUN = 2'b01   // words flowing
  } link_state_e;

endpackage : pp_words_pkg

// ### rtl/pin_sync.sv
// pin_sync: two-flop synchroniser for a group of asynchronous pin levels.
// assumes: pins are slow levels, no bus coherency needed between bits.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] pin_sync_q
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // two flops in series; the first never feeds logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      meta_q <= pin_async;
      pin_sync_q <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### rtl/edge_detect.sv
// edge_detect: rising-edge finder between successive received words.
// assumes: word_valid marks a fresh cyclic word; edges counted once per word.
`timescale 1ns/1ns
`default_nettype none
module edge_detect #(
  parameter int unsigned W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic word_valid,
  input wire logic [W-1:0] word,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev_q; // previous received word

  // a rise is a bit that was 0 in the last word and is 1 in this one
  assign rise = word_valid ? (word & ~prev_q) : '0;

  // remember the last accepted word only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_q <= '0;
    end else if (word_valid) begin
      prev_q <= word;
    end
  end
endmodule : edge_detect
`default_nettype wire

// ### rtl/pp_words.sv
// pp_words: interpreter for the cyclic process words of programmable positioning.
// assumes: link layer presents all four words with a one-cycle strobe;
// engines sit on sys_clk; pins come in asynchronously.
//
// Contract
// - start needs word1 bit0 and enable
// - bit2 emergency stop, bit3 external error
// - bit7 rising edge clears pending error
// - bits12..15 drive outputs 3..0 if option two
// - word2 bits0..7 set flags 90..97
// - word2 bit8 selects manual or automatic
// - bit9 rise in automatic starts program
// - bit9 rise in manual starts referencing
// - word2 bit10 high aborts program sequence
// - word2 bit11 high brakes to standstill
// - jog bits 14/15 only when bit0 low
// - no controlled operation without hardware enable; only bit0 start is gated, not jog or the bit9 start pulses
// - status1 error, constant one, power, ready
// - status1 reached, limit, zero speed, stop
// - status1 mirrors enable, outputs, inputs
// - status2 bits0..7 mirror flags 80..87
// - status2 bit8 reference point defined
// - status2 bit9 shows automatic mode
// - status2 bit10 shows program active
// - status2 bits12/13 feed hold, update
// - status2 bits14/15 sync, lag limit
// - words3/4 carry variable, high first
`timescale 1ns/1ns
`default_nettype none
module pp_words (
  input wire logic sys_clk,
  input wire logic rst,
  // received cyclic words from the link layer
  input wire logic rx_valid,
  input wire pp_words_pkg::rx_words_s rx_words,
  // returned cyclic words to the link layer
  output pp_words_pkg::rx_words_s tx_words,
  // variable 98 as written by the program engine
  input wire logic [31:0] var_from_prog,
  input wire logic var_from_prog_we,
  output logic [31:0] program_variable_slot,
  // engine status in, commands out
  input wire pp_words_pkg::engine_state_s engine_state,
  output pp_words_pkg::drive_cmd_s drive_cmd,
  // output function selectors, 4 bits each
  input wire logic [3:0] output0_function_select,
  input wire logic [3:0] output1_function_select,
  input wire logic [3:0] output2_function_select,
  input wire logic [3:0] output3_function_select,
  // outputs owned by other functions when not bus-controlled
  input wire logic [3:0] outputs_local,
  output logic [3:0] digital_outputs,
  // asynchronous pins
  input wire logic hardware_enable_input,
  input wire logic [4:0] digital_inputs
);
  import pp_words_pkg::*;

  logic [5:0] pins_sync;           // {inputs 4..0, enable} after two flops
  logic enable_s;                  // synchronised hardware enable
  logic [4:0] inputs_s;            // synchronised inputs 4..0
  logic [15:0] cw1_q;              // last drive control word
  logic [15:0] cw2_q;              // last program control word
  logic [15:0] rise1;              // edges on word1
  logic [15:0] rise2;              // edges on word2
  logic err_clear_q;               // error clear pulse
  logic prog_start_q;              // program start pulse
  logic ref_start_q;               // reference start pulse
  logic [31:0] var_q;              // program variable 98
  logic [3:0] out_q;               // registered digital outputs
  logic [15:0] sw1_d;              // status word 1 next
  logic [15:0] sw2_d;              // status word 2 next
  logic [15:0] sw1_q;
  logic [15:0] sw2_q;
  link_state_e link_q;             // whether any word has arrived
  logic [3:0] bus_owned;           // output i handed to the bus

  // selector test used for all four outputs
  function automatic logic sel_bus(input logic [3:0] sel);
    sel_bus = (sel == OUTPUT_OPTION_TWO);
  endfunction : sel_bus

  // pins cross into sys_clk before anything reads them
  pin_sync #(
    .W(6)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_async({digital_inputs, hardware_enable_input}),
    .pin_sync_q(pins_sync)
  );
  assign enable_s = pins_sync[0];
  assign inputs_s = pins_sync[5:1];

  // edge finders compare each new word with the previous one
  edge_detect #(
    .W(16)
  ) u_edge1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .word_valid(rx_valid),
    .word(rx_words.word1),
    .rise(rise1)
  );
  edge_detect #(
    .W(16)
  ) u_edge2 (
    .sys_clk(sys_clk),
    .rst(rst),
    .word_valid(rx_valid),
    .word(rx_words.word2),
    .rise(rise2)
  );

  // link state: commands stay idle until the first word lands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_q <= LINK_IDLE;
    end else begin
      unique case (link_q)
        LINK_IDLE: if (rx_valid) link_q <= LINK_RUN;
        LINK_RUN: link_q <= LINK_RUN;
      endcase
    end
  end

  // latch control words; levels hold between bus cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cw1_q <= CW_RESET;
      cw2_q <= CW_RESET;
    end else if (rx_valid) begin
      cw1_q <= rx_words.word1;
      cw2_q <= rx_words.word2;
    end
  end

  // one pulse per detected rising edge, not per level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_clear_q <= 1'b0;
      prog_start_q <= 1'b0;
      ref_start_q <= 1'b0;
    end else begin
      err_clear_q <= rise1[CW1_ERR_CLR];
      prog_start_q <= rise2[CW2_TRIG] & rx_words.word2[CW2_AUTO];
      ref_start_q <= rise2[CW2_TRIG] & ~rx_words.word2[CW2_AUTO];
    end
  end

  // variable 98: bus write wins over engine write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      var_q <= VAR_RESET;
    end else if (rx_valid) begin
      var_q <= {rx_words.word3, rx_words.word4};
    end else if (var_from_prog_we) begin
      var_q <= var_from_prog;
    end
  end
  assign program_variable_slot = var_q;

  // which outputs the bus owns
  assign bus_owned = {sel_bus(output3_function_select), sel_bus(output2_function_select),
                      sel_bus(output1_function_select), sel_bus(output0_function_select)};

  // outputs: word1 bit12->out3 .. bit15->out0 where selected
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // bit index counts down as output number counts up
        out_q[i] <= bus_owned[i] ? cw1_q[CW1_OUT_LSB + 3 - i] : outputs_local[i];
      end
    end
  end
  assign digital_outputs = out_q;

  // decoded commands; all levels need a received word first
  always_comb begin
    drive_cmd = '0;
    if (link_q == LINK_RUN) begin
      // start only with hardware enable present
      drive_cmd.drive_enable = cw1_q[CW1_START] & enable_s;
      drive_cmd.estop = cw1_q[CW1_ESTOP];
      drive_cmd.ext_err = cw1_q[CW1_EXT_ERR];
      drive_cmd.auto_mode = cw2_q[CW2_AUTO];
      drive_cmd.prog_abort = cw2_q[CW2_UPDATE];
      drive_cmd.feed_hold = cw2_q[CW2_FEED];
      // jog only when start is off, and only in manual mode
      drive_cmd.jog_pos = cw2_q[CW2_JOG_POS] & ~cw1_q[CW1_START] & ~cw2_q[CW2_AUTO];
      drive_cmd.jog_neg = cw2_q[CW2_JOG_NEG] & ~cw1_q[CW1_START] & ~cw2_q[CW2_AUTO];
      drive_cmd.flags_in = cw2_q[CW2_FLAG_LSB +: 8];
    end
    drive_cmd.err_clear = err_clear_q;
    drive_cmd.prog_start = prog_start_q;
    drive_cmd.ref_start = ref_start_q;
  end

  // assemble status word 1
  always_comb begin
    sw1_d = 16'h0000;
    sw1_d[SW1_GEN_ERR] = engine_state.gen_err;
    sw1_d[SW1_ONE] = 1'b1;
    sw1_d[SW1_POS_REACHED] = engine_state.pos_reached;
    sw1_d[SW1_REF_LIMIT] = engine_state.ref_limit;
    // no power stage without hardware enable
    sw1_d[SW1_POWER] = engine_state.power_on & enable_s;
    sw1_d[SW1_ZERO_SPEED] = engine_state.zero_speed;
    sw1_d[SW1_ESTOP] = cw1_q[CW1_ESTOP];
    sw1_d[SW1_READY] = engine_state.ready;
    sw1_d[SW1_ENABLE] = enable_s;
    sw1_d[SW1_OUT0] = out_q[0];
    sw1_d[SW1_OUT1] = out_q[1];
    // inputs 4..0 sit on bits 11..15
    for (int i = 0; i < 5; i++) begin
      sw1_d[SW1_IN_LSB + i] = inputs_s[4 - i];
    end
  end

  // assemble status word 2
  always_comb begin
    sw2_d = 16'h0000;
    sw2_d[SW2_FLAG_LSB +: 8] = engine_state.flags_out;
    sw2_d[SW2_REF_DONE] = engine_state.ref_done;
    sw2_d[SW2_AUTO] = cw2_q[CW2_AUTO];
    sw2_d[SW2_PROG] = engine_state.prog_active;
    // 1 reads as set, so the control level is echoed
    sw2_d[SW2_FEED] = cw2_q[CW2_FEED];
    sw2_d[SW2_UPDATE] = cw2_q[CW2_UPDATE];
    sw2_d[SW2_SYNC] = engine_state.sync_active;
    sw2_d[SW2_LAG] = engine_state.lag_limit;
  end

  // register the status words so the link sees stable data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw1_q <= 16'h0000;
      sw2_q <= 16'h0000;
    end else begin
      sw1_q <= sw1_d;
      sw2_q <= sw2_d;
    end
  end

  // returned words; variable split high half first
  assign tx_words.word1 = sw1_q;
  assign tx_words.word2 = sw2_q;
  assign tx_words.word3 = var_q[31:16];
  assign tx_words.word4 = var_q[15:0];

endmodule : pp_words
`default_nettype wire

// ### sim/pp_words_asserts.sv
// pp_words_asserts: port-level checks for the process-word interpreter.
// assumes: bound into pp_words; one sys_clk domain with synchronous rst.
`timescale 1ns/1ns
`default_nettype none
module pp_words_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire pp_words_pkg::rx_words_s rx_words,
  input wire pp_words_pkg::rx_words_s tx_words,
  input wire logic [31:0] program_variable_slot,
  input wire pp_words_pkg::engine_state_s engine_state,
  input wire pp_words_pkg::drive_cmd_s drive_cmd,
  input wire logic [3:0] output3_function_select,
  input wire logic [3:0] digital_outputs,
  input wire logic hardware_enable_input
);
  import pp_words_pkg::*;
  logic [15:0] w1_q; // last taken drive word
  logic [15:0] w2_q; // last taken program word
  // previous words, kept so that 0->1 changes can be seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w1_q <= '0;
      w2_q <= '0;
    end else if (rx_valid) begin
      w1_q <= rx_words.word1;
      w2_q <= rx_words.word2;
    end
  end
  wire logic clr_rise = rx_valid && rx_words.word1[7] && !w1_q[7]; // error clear edge
  wire logic trig_rise = rx_valid && rx_words.word2[9] && !w2_q[9]; // start edge
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_clear_on_rise: assert property (clr_rise |=> drive_cmd.err_clear)
    else $error("error clear pulse missing");
  a_clear_no_level: assert property (!clr_rise |=> !drive_cmd.err_clear)
    else $error("error clear without a rising edge");
  a_prog_start: assert property (trig_rise && rx_words.word2[8] |=>
    drive_cmd.prog_start && !drive_cmd.ref_start)
    else $error("program start pulse wrong");
  a_ref_start: assert property (trig_rise && !rx_words.word2[8] |=>
    drive_cmd.ref_start && !drive_cmd.prog_start)
    else $error("reference run pulse wrong");
  a_level_decode: assert property (
    drive_cmd.estop == w1_q[2] && drive_cmd.ext_err == w1_q[3]
    && drive_cmd.flags_in == w2_q[7:0] && drive_cmd.auto_mode == w2_q[8]
    && drive_cmd.prog_abort == w2_q[10] && drive_cmd.feed_hold == w2_q[11])
    else $error("command levels differ from last word");
  a_jog_gate: assert property (
    drive_cmd.jog_pos == (w2_q[14] && !w1_q[0] && !w2_q[8])
    && drive_cmd.jog_neg == (w2_q[15] && !w1_q[0] && !w2_q[8]))
    else $error("jog command not gated");
  a_start_needs_bit: assert property (drive_cmd.drive_enable |-> w1_q[0])
    else $error("drive enabled without start bit");
  a_no_hw_enable: assert property (!hardware_enable_input [*5] |->
    !drive_cmd.drive_enable)
    else $error("drive enabled without hardware enable");
  a_always_one: assert property (!$past(rst) |-> tx_words.word1[SW1_ONE])
    else $error("status bit one not set");
  a_status2_map: assert property (!$past(rst) |->
    tx_words.word2[7:0] == $past(engine_state.flags_out)
    && tx_words.word2[8] == $past(engine_state.ref_done)
    && tx_words.word2[10] == $past(engine_state.prog_active)
    && tx_words.word2[15:14] == $past({engine_state.lag_limit, engine_state.sync_active}))
    else $error("program status word mapping wrong");
  a_var_halves: assert property ({tx_words.word3, tx_words.word4} == program_variable_slot)
    else $error("variable halves out of order");
  a_var_load: assert property (rx_valid |=>
    program_variable_slot == $past({rx_words.word3, rx_words.word4}))
    else $error("variable not taken from words three and four");
  a_out3_drive: assert property (rx_valid && output3_function_select == OUTPUT_OPTION_TWO
    |-> ##2 digital_outputs[3] == $past(rx_words.word1[12], 2))
    else $error("output three not driven from bit twelve");
  c_prog_start: cover property (drive_cmd.prog_start);
  c_ref_start: cover property (drive_cmd.ref_start);
  c_err_clear: cover property (drive_cmd.err_clear);
endmodule : pp_words_asserts
bind pp_words pp_words_asserts chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .rx_valid(rx_valid),
  .rx_words(rx_words),
  .tx_words(tx_words),
  .program_variable_slot(program_variable_slot),
  .engine_state(engine_state),
  .drive_cmd(drive_cmd),
  .output3_function_select(output3_function_select),
  .digital_outputs(digital_outputs),
  .hardware_enable_input(hardware_enable_input)
);
`default_nettype wire

// ### sim/plc_model.sv
// plc_model: bus master side, offers one cyclic word set per call.
// assumes: link layer is transparent; a set is presented for one cycle.
`timescale 1ns/1ns
`default_nettype none
module plc_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output pp_words_pkg::rx_words_s rx_words
);
  import pp_words_pkg::*;
  // idle: nothing offered yet
  initial begin
    rx_valid = 1'b0;
    rx_words = '0;
  end
  // one set: strobe for one cycle, then the words go stale
  task automatic send(input logic [15:0] w1, input logic [15:0] w2, input logic [31:0] pv);
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b1;
    rx_words = '{w1, w2, pv[31:16], pv[15:0]};
    @(posedge sys_clk);
    #1;
    rx_valid = 1'b0;
    // stale words inverted so nothing can lean on a held bus
    rx_words = ~rx_words;
  endtask : send
endmodule : plc_model
`default_nettype wire

// ### sim/testbench.sv
// testbench: table-driven check of the process-word interpreter.
// assumes: plc_model offers the words; engines and pins are driven here.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench;
  import pp_words_pkg::*;
  logic sys_clk;
  logic rst;
  logic rx_valid;
  rx_words_s rx_words;
  rx_words_s tx_words;
  logic [31:0] var_from_prog;
  logic var_from_prog_we;
  logic [31:0] program_variable_slot;
  engine_state_s engine_state;
  drive_cmd_s drive_cmd;
  logic [3:0] out_sel_bus; // selector of outputs 0, 2 and 3
  logic [3:0] out_sel_1; // output 1 stays local
  logic [3:0] outputs_local;
  logic [3:0] digital_outputs;
  logic hardware_enable_input;
  logic [4:0] digital_inputs;
  int num_errors;
  int check_count;
  typedef struct {logic [15:0] w1; logic [15:0] w2; logic [18:0] cmd;} row_s;
  // word pairs and the command they give, taken in this order
  row_s rows [10] = '{
    '{16'h0001, 16'h0000, 19'h40000},
    '{16'h0085, 16'h00A5, 19'h680A5},
    '{16'h0088, 16'h0100, 19'h14000},
    '{16'h0000, 16'h0300, 19'h06000},
    '{16'h0000, 16'h0000, 19'h00000},
    '{16'h0000, 16'h0200, 19'h01000},
    '{16'h0000, 16'h4C00, 19'h00E00},
    '{16'h0001, 16'h8000, 19'h40000},
    '{16'h0000, 16'h8000, 19'h00100},
    '{16'h0080, 16'h00FF, 19'h080FF}};
  plc_model plc (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_words(rx_words));
  pp_words uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_words(rx_words),
    .tx_words(tx_words),
    .var_from_prog(var_from_prog),
    .var_from_prog_we(var_from_prog_we),
    .program_variable_slot(program_variable_slot),
    .engine_state(engine_state),
    .drive_cmd(drive_cmd),
    .output0_function_select(out_sel_bus),
    .output1_function_select(out_sel_1),
    .output2_function_select(out_sel_bus),
    .output3_function_select(out_sel_bus),
    .outputs_local(outputs_local),
    .digital_outputs(digital_outputs),
    .hardware_enable_input(hardware_enable_input),
    .digital_inputs(digital_inputs)
  );
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end
  // n edges, then the usual 1 ns so inputs never move on the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    $display("ERROR watchdog expired");
    final_report();
  end
  initial begin
    rst = 1'b1;
    var_from_prog = 32'h0;
    var_from_prog_we = 1'b0;
    engine_state = '0;
    out_sel_bus = OUTPUT_OPTION_TWO;
    out_sel_1 = 4'h0;
    outputs_local = 4'h0;
    hardware_enable_input = 1'b0;
    digital_inputs = 5'h00;
    num_errors = 0;
    check_count = 0;
    tick(20);
    `CHK("cmd_in_reset", drive_cmd, 19'h0)
    rst = 1'b0;
    tick(2);
    `CHK("status1_idle", tx_words.word1, 16'h0002)
    $display("reset test done");
    // enable must be through its synchroniser before the table
    hardware_enable_input = 1'b1;
    tick(5);
    foreach (rows[i]) begin
      plc.send(rows[i].w1, rows[i].w2, 32'h0);
      `CHK("drive_cmd", drive_cmd, rows[i].cmd)
    end
    $display("row table done");
    outputs_local = 4'h2;
    // error, reached, power, zero speed, ready, ref done, program, sync; flags 3C
    engine_state = 18'h37E3C;
    digital_inputs = 5'h03;
    plc.send(16'hA000, 16'h0D00, 32'h0032C000);
    tick(4);
    `CHK("outputs", digital_outputs, 4'h7)
    `CHK("status1", tx_words.word1, 16'hC7B7)
    `CHK("status2", tx_words.word2, 16'h773C)
    `CHK("variable", {tx_words.word3, tx_words.word4}, 32'h0032C000)
    var_from_prog = 32'h89ABCDEF;
    var_from_prog_we = 1'b1;
    tick(1);
    var_from_prog_we = 1'b0;
    tick(1);
    `CHK("var_engine", {tx_words.word3, tx_words.word4}, 32'h89ABCDEF)
    $display("status test done");
    hardware_enable_input = 1'b0;
    plc.send(16'h0001, 16'h00F0, 32'h0);
    tick(4);
    `CHK("no_enable", drive_cmd.drive_enable, 1'b0)
    `CHK("enable_bits", {tx_words.word1[8], tx_words.word1[4]}, 2'b00)
    rst = 1'b1;
    tick(2);
    `CHK("cmd_mid_reset", drive_cmd, 19'h0)
    rst = 1'b0;
    tick(2);
    `CHK("cmd_after_reset", drive_cmd, 19'h0)
    $display("enable and reset test done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
